//--- oasp_pkg.sv
// Constants and types for the OR and stack-pop execution block
package oasp_pkg;

	localparam logic [7:0] OASP_ESCAPE = 8'hA5;
	localparam logic [7:0] OASP_PORT_BASE = 8'h80;
	localparam logic [7:0] OASP_PORT_STEP = 8'h10;
	localparam logic [7:0] OASP_PORT_LAST = 8'hB0;
	localparam logic [7:0] OASP_SP_ADDR = 8'h81;
	localparam logic [15:0] OASP_SP_RESET = 16'h0007;
	localparam int OASP_CLOCK_HZ = 10_000_000;
	localparam logic [2:0] OASP_EXTRA_DIR_A = 3'h2;
	localparam logic [2:0] OASP_EXTRA_ONE = 3'h1;

	// Operation selected by the decoder
	typedef enum logic [3:0] {
		OASP_OP_NONE = 4'h0,
		OASP_OP_OR_DIR_A = 4'h1,
		OASP_OP_OR_DIR_IMM = 4'h2,
		OASP_OP_OR_A_IMM = 4'h3,
		OASP_OP_OR_A_DIR = 4'h4,
		OASP_OP_OR_A_IND = 4'h5,
		OASP_OP_OR_A_REG = 4'h6,
		OASP_OP_OR_EXT = 4'h7,
		OASP_OP_OR_CY_BIT = 4'h8,
		OASP_OP_OR_CY_NBIT = 4'h9,
		OASP_OP_POP8 = 4'hA,
		OASP_OP_POP16 = 4'hB
	} oasp_op_t;

	// Decoded instruction
	typedef struct packed {
		oasp_op_t op;
		logic [7:0] dir;
		logic [15:0] imm;
		logic wide;
	} oasp_dec_t;

	// Execution states, Gray coded along the path through OASP_WAIT
	typedef enum logic [2:0] {
		OASP_IDLE = 3'b000,
		OASP_READ = 3'b001,
		OASP_EXEC = 3'b011,
		OASP_WAIT = 3'b010,
		OASP_WRITE = 3'b110
	} oasp_state_t;

	// Data-memory access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wide;
	} oasp_mem_t;

endpackage : oasp_pkg

//--- oasp_decoder.sv
// Opcode decoder for OR and pop forms with escape-prefix handling
`timescale 1ns/1ps
module oasp_decoder
	import oasp_pkg::*;
(
	input wire logic source_mode_i,
	input wire logic escaped_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] sub_i,
	output oasp_op_t op_o
);
	logic ext_map;

	// In source mode the prefix swaps the maps back to the short forms
	assign ext_map = source_mode_i ^ escaped_i;

	always_comb begin
		op_o = OASP_OP_NONE;
		case (opcode_i)
			8'h42: op_o = OASP_OP_OR_DIR_A;
			8'h43: op_o = OASP_OP_OR_DIR_IMM;
			8'h44: op_o = OASP_OP_OR_A_IMM;
			8'h45: op_o = OASP_OP_OR_A_DIR;
			8'h72: op_o = OASP_OP_OR_CY_BIT;
			8'hA0: op_o = OASP_OP_OR_CY_NBIT;
			8'hD0: op_o = OASP_OP_POP8;
			8'hDA: begin
				if (ext_map) begin
					op_o = (sub_i[3:0] == 4'h8) ? OASP_OP_POP8 : OASP_OP_POP16;
				end
			end
			default: begin
				if (opcode_i[7:4] == 4'h4 && opcode_i[3:0] >= 4'hC) begin
					// Short register forms share this range in the other map
					op_o = ext_map ? OASP_OP_OR_EXT : OASP_OP_OR_A_REG;
				end else if (opcode_i[7:1] == 7'h23) begin
					op_o = ext_map ? OASP_OP_NONE : OASP_OP_OR_A_IND;
				end else if (opcode_i[7:3] == 5'h09) begin
					op_o = ext_map ? OASP_OP_NONE : OASP_OP_OR_A_REG;
				end
			end
		endcase
	end
endmodule : oasp_decoder

//--- oasp_core.sv
// Execution unit for logical OR and stack pop
`timescale 1ns/1ps
module oasp_core
	import oasp_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic source_mode_i,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] sub_i,
	input wire logic [7:0] dir_i,
	input wire logic [15:0] imm_i,
	input wire logic src_bit_i,
	input wire logic [15:0] reg_i,
	input wire logic [15:0] mem_rdata_i,
	input wire logic [7:0] port_latch_i,
	output oasp_mem_t mem_o,
	output logic [15:0] reg_wdata_o,
	output logic reg_we_o,
	output logic carry_flag_o,
	output logic [15:0] stack_pointer_o,
	output logic busy_o,
	output logic done_o
);
	typedef struct packed {
		oasp_state_t state;
		oasp_op_t op;
		logic escaped;
		logic [7:0] dir;
		logic [15:0] imm;
		logic [15:0] operand;
		logic [2:0] extra;
		logic carry_flag;
		logic [15:0] stack_pointer;
		oasp_mem_t mem;
		logic [15:0] reg_wdata;
		logic reg_we;
		logic done;
	} oasp_core_t;

	oasp_core_t s;
	oasp_core_t next_s;
	oasp_op_t dec_op;
	logic is_port;
	logic [15:0] src_val;
	logic bit_val;

	oasp_decoder oasp_decoder_inst (
		.source_mode_i(source_mode_i),
		.escaped_i(s.escaped),
		.opcode_i(opcode_i),
		.sub_i(sub_i),
		.op_o(dec_op)
	);

	// ----------------------------------------
	// Port detection and operand sourcing
	// ----------------------------------------
	assign is_port = (s.dir[3:0] == 4'h0) && (s.dir >= OASP_PORT_BASE)
		&& (s.dir <= OASP_PORT_LAST);

	// Reading the latch keeps a read-modify-write from copying pin loading
	assign src_val = is_port ? {8'h00, port_latch_i} : mem_rdata_i;
	assign bit_val = (s.op == OASP_OP_OR_CY_NBIT) ? ~src_bit_i : src_bit_i;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.reg_we = 1'b0;
		next_s.mem.rd = 1'b0;
		next_s.mem.wr = 1'b0;
		case (s.state)
			OASP_IDLE: begin
				if (start_i) begin
					if (opcode_i == OASP_ESCAPE && !s.escaped) begin
						next_s.escaped = 1'b1;
					end else begin
						next_s.escaped = 1'b0;
						next_s.op = dec_op;
						next_s.dir = dir_i;
						next_s.imm = imm_i;
						next_s.extra = 3'h0;
						next_s.state = OASP_READ;
						if (dec_op == OASP_OP_POP8 || dec_op == OASP_OP_POP16) begin
							next_s.mem.rd = 1'b1;
							next_s.mem.addr = s.stack_pointer;
							next_s.mem.wide = (dec_op == OASP_OP_POP16);
						end else begin
							next_s.mem.rd = 1'b1;
							next_s.mem.addr = {8'h00, dir_i};
							next_s.mem.wide = 1'b0;
						end
					end
				end
			end
			OASP_READ: begin
				next_s.operand = src_val;
				next_s.state = OASP_EXEC;
				case (s.op)
					OASP_OP_OR_DIR_A: next_s.extra = is_port ? OASP_EXTRA_DIR_A : 3'h0;
					OASP_OP_OR_DIR_IMM: next_s.extra = is_port ? OASP_EXTRA_ONE : 3'h0;
					OASP_OP_OR_A_DIR: next_s.extra = is_port ? OASP_EXTRA_ONE : 3'h0;
					OASP_OP_OR_CY_BIT, OASP_OP_OR_CY_NBIT: begin
						next_s.extra = is_port ? OASP_EXTRA_ONE : 3'h0;
					end
					default: next_s.extra = 3'h0;
				endcase
			end
			OASP_EXEC: begin
				next_s.state = (s.extra != 3'h0) ? OASP_WAIT : OASP_WRITE;
			end
			OASP_WAIT: begin
				next_s.extra = s.extra - 3'h1;
				if (s.extra == 3'h1) begin
					next_s.state = OASP_WRITE;
				end
			end
			OASP_WRITE: begin
				next_s.state = OASP_IDLE;
				next_s.done = 1'b1;
				case (s.op)
					OASP_OP_OR_DIR_A, OASP_OP_OR_DIR_IMM: begin
						next_s.mem.wr = 1'b1;
						next_s.mem.addr = {8'h00, s.dir};
						next_s.mem.wide = 1'b0;
						next_s.mem.wdata = {8'h00, s.operand[7:0]
							| ((s.op == OASP_OP_OR_DIR_A) ? reg_i[7:0] : s.imm[7:0])};
					end
					OASP_OP_OR_A_IMM: begin
						next_s.reg_we = 1'b1;
						next_s.reg_wdata = reg_i | s.imm;
					end
					OASP_OP_OR_A_DIR, OASP_OP_OR_A_IND, OASP_OP_OR_A_REG, OASP_OP_OR_EXT: begin
						next_s.reg_we = 1'b1;
						next_s.reg_wdata = reg_i | s.operand;
					end
					OASP_OP_OR_CY_BIT, OASP_OP_OR_CY_NBIT: begin
						next_s.carry_flag = s.carry_flag | bit_val;
					end
					OASP_OP_POP8, OASP_OP_POP16: begin
						next_s.stack_pointer = s.stack_pointer
							- (s.op == OASP_OP_POP16 ? 16'h0002 : 16'h0001);
						if (s.dir == OASP_SP_ADDR) begin
							next_s.stack_pointer = s.operand;
						end else begin
							next_s.reg_we = 1'b1;
							next_s.reg_wdata = (s.op == OASP_OP_POP16)
								? s.operand : {8'h00, s.operand[7:0]};
						end
					end
					default: next_s.done = 1'b1;
				endcase
			end
			default: next_s.state = OASP_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.stack_pointer <= OASP_SP_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign mem_o = s.mem;
	assign reg_wdata_o = s.reg_wdata;
	assign reg_we_o = s.reg_we;
	assign carry_flag_o = s.carry_flag;
	assign stack_pointer_o = s.stack_pointer;
	assign busy_o = (s.state != OASP_IDLE);
	assign done_o = s.done;
endmodule : oasp_core

//--- oasp_core_sva.sv
// Port assertions for the OR and stack-pop execution core
`timescale 1ns/1ps
module oasp_core_chk
	import oasp_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] dir_i,
	input wire logic src_bit_i,
	input wire logic [15:0] mem_rdata_i,
	input oasp_mem_t mem_o,
	input wire logic carry_flag_o,
	input wire logic [15:0] stack_pointer_o,
	input wire logic busy_o,
	input wire logic done_o
);
	// ---
	// Checks
	// ---
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire logic go = start_i && !busy_o;
	wire logic port = dir_i[7] && !dir_i[6] && dir_i[3:0] == 4'h0;
	sequence s_base;
		!done_o [*3] ##1 done_o;
	endsequence
	sequence s_one;
		!done_o ##1 s_base;
	endsequence
	a_dir_a_port: assert property (go && opcode_i == 8'h42 && port |=> !done_o ##1 s_one)
		else $error("port OR from accumulator took wrong time");
	a_dir_imm_port: assert property (go && opcode_i == 8'h43 && port |=> s_one)
		else $error("port OR immediate took wrong time");
	a_a_dir_port: assert property (go && opcode_i == 8'h45 && port |=> s_one)
		else $error("OR from port took wrong time");
	a_carry_set: assert property (go && opcode_i == 8'h72 && src_bit_i && !port |-> ##5 carry_flag_o)
		else $error("carry not set by one bit");
	a_carry_keep: assert property (carry_flag_o |=> carry_flag_o)
		else $error("carry cleared");
	a_nbit_set: assert property (go && opcode_i == 8'ha0 && !src_bit_i && !port |-> ##5 carry_flag_o)
		else $error("carry not set by inverted zero");
	a_pop_addr: assert property (go && opcode_i == 8'hd0 |=> mem_o.rd && mem_o.addr == $past(stack_pointer_o))
		else $error("pop read not at stack pointer");
	a_pop_dec: assert property (go && opcode_i == 8'hd0 && dir_i != 8'h81
		|-> ##5 stack_pointer_o == $past(stack_pointer_o, 5) - 16'h0001)
		else $error("pop did not decrement by one");
	a_pop_sp_wins: assert property (go && opcode_i == 8'hd0 && dir_i == 8'h81
		|-> ##5 stack_pointer_o == $past(mem_rdata_i, 4))
		else $error("popped value lost in stack pointer");
endmodule : oasp_core_chk

//--- test_or_and_stack_pop_execution.sv
// Self-checking bench for the OR and stack-pop execution core
`timescale 1ns/1ps
`define CHK(n,e,a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("Error %s exp %h got %h", n, e, a); end end
module test_or_and_stack_pop_execution;
	import oasp_pkg::*;
	logic clock_i = 0, resetn_i = 0, source_mode_i = 0, start_i = 0, src_bit_i = 0, we;
	logic [7:0] opcode_i = 0, sub_i = 0, dir_i = 0, port_latch_i = 8'h0c;
	logic [15:0] imm_i = 16'h0030, reg_i = 16'h00c3, mem_rdata_i = 16'h0055, wd;
	logic [15:0] reg_wdata_o, stack_pointer_o;
	logic reg_we_o, carry_flag_o, busy_o, done_o;
	oasp_mem_t mem_o, wr;
	int error_cnt = 0, n_checks = 0, lat;
	oasp_core oasp_core_inst(.*);
	initial forever #50 clock_i = ~clock_i;
	// ---
	// Tasks
	// ---
	task automatic go(input logic [7:0] op, d, input bit pfx, input int n);
		@(posedge clock_i) #1;
		start_i = 1;
		if (pfx) begin
			opcode_i = 8'ha5;
			@(posedge clock_i) #1;
		end
		opcode_i = op;
		dir_i = d;
		we = 0;
		wr = '0;
		@(posedge clock_i) #1;
		start_i = 0;
		lat = 1;
		while (done_o !== 1'b1 && lat < 20) begin
			@(posedge clock_i) #1;
			lat++;
			if (mem_o.wr) wr = mem_o;
			if (reg_we_o) begin
				we = 1;
				wd = reg_wdata_o;
			end
		end
		`CHK("latency", n, lat)
	endtask : go
	task automatic t_or;
		go(8'h42, 8'h20, 0, 4);
		`CHK("or dir,a", 8'hd7, wr.wdata[7:0])
		go(8'h42, 8'h90, 0, 6);
		`CHK("or port,a", 8'hcf, wr.wdata[7:0])
		go(8'h43, 8'h40, 0, 4);
		`CHK("or dir,imm", 8'h75, wr.wdata[7:0])
		go(8'h43, 8'h80, 0, 5);
		`CHK("or port,imm", 8'h3c, wr.wdata[7:0])
		go(8'h45, 8'hb0, 0, 5);
		`CHK("or a,port", 8'hcf, wd[7:0])
		go(8'h44, 8'h20, 0, 4);
		`CHK("or a,imm", 16'h00f3, wd)
		$display("t_or done");
	endtask : t_or
	task automatic t_carry;
		logic [7:0] op [4] = '{8'h72, 8'ha0, 8'ha0, 8'h72};
		logic [3:0] b = 4'b0010;
		logic [3:0] c = 4'b1100;
		for (int i = 0; i < 4; i++) begin
			src_bit_i = b[i];
			go(op[i], 8'h20, 0, 4);
			`CHK("carry", c[i], carry_flag_o)
		end
		@(posedge clock_i) #1;
		resetn_i = 0;
		@(posedge clock_i) #1;
		resetn_i = 1;
		`CHK("carry mid reset", 1'b0, carry_flag_o)
		src_bit_i = 1;
		go(8'h72, 8'h20, 0, 4);
		`CHK("carry set", 1'b1, carry_flag_o)
		src_bit_i = 0;
		$display("t_carry done");
	endtask : t_carry
	task automatic t_escape;
		source_mode_i = 1;
		go(8'h48, 8'h20, 0, 4);
		`CHK("short unescaped", 1'b0, we)
		go(8'h48, 8'h20, 1, 4);
		`CHK("short escaped", 1'b1, we)
		source_mode_i = 0;
		$display("t_escape done");
	endtask : t_escape
	task automatic t_pop;
		mem_rdata_i = 16'h0020;
		go(8'hd0, 8'h30, 0, 4);
		@(posedge clock_i) #1;
		`CHK("pop data", 16'h0020, wd)
		`CHK("pop sp", 16'h0006, stack_pointer_o)
		sub_i = 8'h09;
		mem_rdata_i = 16'h1234;
		go(8'hda, 8'h30, 1, 4);
		`CHK("pop word data", 16'h1234, wd)
		`CHK("pop word sp", 16'h0004, stack_pointer_o)
		mem_rdata_i = 16'h0020;
		go(8'hd0, 8'h81, 0, 4);
		@(posedge clock_i) #1;
		`CHK("pop into sp", 16'h0020, stack_pointer_o)
		$display("t_pop done");
	endtask : t_pop
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20) @(posedge clock_i);
		#1 resetn_i = 1;
		`CHK("sp reset", OASP_SP_RESET, stack_pointer_o)
		`CHK("carry reset", 1'b0, carry_flag_o)
		t_or;
		t_carry;
		t_escape;
		t_pop;
		test_done;
	end
	// Whole run is about 110 cycles; about eighteen times that means a hang
	initial begin
		#(100 * 2000);
		error_cnt++;
		test_done;
	end
endmodule : test_or_and_stack_pop_execution
bind oasp_core oasp_core_chk oasp_core_chk_inst(.*);
